// ---- src/main_clock_consts.vh ----
`ifndef MAIN_CLOCK_CONSTS_VH
`define MAIN_CLOCK_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_MAIN_CONTROL_A 8'h00
`define IDX_MAIN_CONTROL_B 8'h01
`define IDX_MAIN_STATUS 8'h03
`define IDX_FAST_RC_CTRL 8'h10
`define IDX_SLOW_OSC_CTRL 8'h18
`define IDX_PROTECT_KEY 8'h20

// main_control_a fields
`define SEL_LSB 0
`define SEL_MSB 1
`define PERIPHERAL_CLOCK_OUT_PIN_BIT 7
`define CTRL_A_RESET 8'h00

// main_control_b fields: enable bit and divider code
`define PEN_BIT 0
`define PDIV_LSB 1
`define PDIV_MSB 4
`define CTRL_B_RESET 8'h11
// divider in use after reset: division minus one, so divide by six
`define DIV_RESET 6'h05

// main_status bit positions
`define ST_CHANGING_BIT 0
`define ST_FAST_BIT 5
`define ST_SLOW_BIT 6
`define ST_EXT_BIT 7

// run-in-standby bit in the oscillator control registers
`define RUN_IN_STANDBY_BIT_BIT 1

// source select codes
`define SRC_FAST 2'h0
`define SRC_SLOW 2'h1
`define SRC_EXT 2'h2

// sleep mode codes
`define MODE_ACTIVE 2'h0
`define MODE_IDLE 2'h1
`define MODE_STANDBY 2'h2
`define MODE_POWERDOWN 2'h3

// timing in oscillator/source cycles; protect window in bus accesses
`define OSC_STARTUP_TICKS 3'h4
`define EXT_STARTUP_EDGES 3'h2
`define PROTECT_WINDOW 3'h4

`endif

// ---- src/main_clock_select_prescaler.v ----
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "main_clock_consts.vh"

// Notes on behaviour
// - requested clocks and sources enable automatically
// - requests routed to the configured source
// - prescaler divides 1 to 64, twelve settings
// - prescaled clock feeds core and peripherals
// - counter clock requested while counter enabled
// - watchdog only when enabled, brownout only when sampled
// - main source follows select field
// - unused sources are switched off
// - run-in-standby keeps oscillator on, except powerdown
// - run-in-standby removes start-up wait
// - main runs active/idle; standby only if needed
// - powerdown stops main after memory completes
// - run-time source change is safe
// - external taken only after stable edges
// - pending external switch locks select until the external source is taken over
// - changing flag set while switch pending
// - external stable flag in status
// - no fallback on external failure
// - select and prescaler need protected writes
// - reset gives fast oscillator, divide by six
// - fuse strap picks 16 or 20 MHz
// - external input starts in two cycles
// - fast oscillator ready after four cycles
module main_clock_select_prescaler #(
  parameter [7:0] PROTECT_KEY = 8'ha5 // arbitrary unlock value
) (
  input wire sys_clk,
  input wire reset_n,
  // avalon-mm slave, byte address
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire avs_waitrequest,
  output wire [31:0] avs_readdata,
  // oscillators: one-cycle ticks on sys_clk
  input wire fast_rc_tick,
  input wire fast_rc_analog_ready,
  input wire slow_osc_tick,
  input wire external_clock_input,
  output wire fast_rc_enable,
  output wire slow_osc_enable,
  output wire ext_pin_clock_mode,
  output wire fast_rc_freq_20m,
  // fuse strap and system state
  input wire frequency_select_field,
  input wire [1:0] sleep_mode,
  input wire nvm_busy,
  input wire periph_main_request,
  input wire rtc_enable,
  input wire rtc_source_ext,
  input wire watchdog_enable,
  input wire brownout_sampled,
  // distributed clock enables
  output wire cpu_clk_en,
  output wire per_clk_en,
  output wire rtc_clk_en,
  output wire watchdog_clock,
  output wire brownout_clock,
  output wire peripheral_clock_out_pin
);

  // bus handshake: one wait cycle per access
  reg ack_q;
  reg [31:0] rdata_q;
  wire req = avs_read | avs_write;
  wire wr_take = avs_write & ack_q;
  wire rd_take = avs_read & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  // register state
  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_b_q;
  reg fast_stby_q;
  reg slow_stby_q;
  reg [2:0] prot_cnt_q; // remaining accesses in the unlock window
  reg ext_lock_q; // set by a request for the external source
  reg freq_q;
  reg strap_done_q;

  // source and prescaler state
  reg [1:0] cur_src_q;
  reg [5:0] pre_cnt_q;
  reg [5:0] div_q; // division minus one in use
  reg [2:0] fast_cnt_q;
  reg [2:0] slow_cnt_q;
  reg [2:0] ext_cnt_q;
  reg cpu_en_q;
  reg peripheral_clock_out_pin_q;

  // external pin synchroniser; a level counts once stages two and three agree
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg ext_lvl_q; // filtered pin level, idle low like the pin after reset
  wire ext_agree = (ext_s2_q == ext_s3_q);
  // one-cycle spikes never reach the edge counter, at one cycle of latency
  wire ext_edge = ext_agree & ext_s3_q & ~ext_lvl_q; // rising edge of agreed level

  // decoded fields
  wire [1:0] tgt_src = ctrl_a_q[`SEL_MSB:`SEL_LSB];
  wire pen = ctrl_b_q[`PEN_BIT];
  wire [3:0] pdiv = ctrl_b_q[`PDIV_MSB:`PDIV_LSB];
  wire unlocked = (prot_cnt_q != 3'h0);
  wire powerdown = (sleep_mode == `MODE_POWERDOWN);
  wire standby = (sleep_mode == `MODE_STANDBY);

  // address decode
  wire hit_a = (avs_address == (`IDX_MAIN_CONTROL_A << 2));
  wire hit_b = (avs_address == (`IDX_MAIN_CONTROL_B << 2));
  wire hit_st = (avs_address == (`IDX_MAIN_STATUS << 2));
  wire hit_fast = (avs_address == (`IDX_FAST_RC_CTRL << 2));
  wire hit_slow = (avs_address == (`IDX_SLOW_OSC_CTRL << 2));
  wire hit_key = (avs_address == (`IDX_PROTECT_KEY << 2));

  // division minus one for each code, twelve settings
  reg [5:0] div_sel;
  always @* begin
    div_sel = 6'h00; // divide by 1 when prescaler off
    if (pen) begin
      case (pdiv)
        4'h0: div_sel = 6'h01;
        4'h1: div_sel = 6'h03;
        4'h2: div_sel = 6'h07;
        4'h3: div_sel = 6'h0f;
        4'h4: div_sel = 6'h1f;
        4'h5: div_sel = 6'h3f;
        4'h8: div_sel = 6'h05;
        4'h9: div_sel = 6'h09;
        4'ha: div_sel = 6'h0b;
        4'hb: div_sel = 6'h17;
        4'hc: div_sel = 6'h2f;
        default: div_sel = 6'h00; // reserved codes act as divide by 1
      endcase
    end
  end

  // readiness of each source
  wire fast_ready = (fast_cnt_q == `OSC_STARTUP_TICKS);
  wire slow_ready = (slow_cnt_q == `OSC_STARTUP_TICKS);
  wire ext_ready = (ext_cnt_q == `EXT_STARTUP_EDGES);

  // main clock demand by sleep mode
  wire cur_stby = (cur_src_q == `SRC_FAST) ? fast_stby_q :
                  (cur_src_q == `SRC_SLOW) ? slow_stby_q : 1'b0;
  wire main_run = (sleep_mode == `MODE_ACTIVE) | (sleep_mode == `MODE_IDLE) |
                  (standby & (periph_main_request | cur_stby)) |
                  nvm_busy;

  // a switch is pending while target and current differ
  wire changing = (tgt_src != cur_src_q);

  // per-source demand
  wire want_fast_main = main_run & ((cur_src_q == `SRC_FAST) | (tgt_src == `SRC_FAST));
  wire want_slow_main = main_run & ((cur_src_q == `SRC_SLOW) | (tgt_src == `SRC_SLOW));
  wire want_ext_main = main_run & ((cur_src_q == `SRC_EXT) | (tgt_src == `SRC_EXT));
  wire rtc_slow = rtc_enable & ~rtc_source_ext;
  wire rtc_ext = rtc_enable & rtc_source_ext;

  // oscillator enables; anything not wanted goes off
  assign fast_rc_enable = want_fast_main | (fast_stby_q & ~powerdown);
  assign slow_osc_enable = want_slow_main | rtc_slow | watchdog_enable |
                           brownout_sampled | (slow_stby_q & ~powerdown);
  assign ext_pin_clock_mode = want_ext_main | rtc_ext;

  // tick of the source in use
  wire cur_tick = (cur_src_q == `SRC_FAST) ? fast_rc_tick :
                  (cur_src_q == `SRC_SLOW) ? slow_osc_tick : ext_edge;
  wire main_tick = cur_tick & main_run;
  wire wrap = main_tick & (pre_cnt_q == div_q);

  // new source may be taken over when ready and at a period boundary or while the main clock is stopped
  // select code 3 has no source behind it, so it never counts as ready
  wire tgt_ready = (tgt_src == `SRC_FAST) ? fast_ready :
                   (tgt_src == `SRC_SLOW) ? slow_ready :
                   (tgt_src == `SRC_EXT) ? ext_ready : 1'b0;
  wire take_switch = changing & tgt_ready & (wrap | ~main_run);

  // asynchronous-source enables follow their requests
  assign rtc_clk_en = rtc_slow ? slow_osc_tick : (rtc_ext & ext_ready & ext_edge);
  assign watchdog_clock = watchdog_enable & slow_osc_tick;
  assign brownout_clock = brownout_sampled & slow_osc_tick;

  // core and peripheral clocks share the prescaled enable
  assign cpu_clk_en = cpu_en_q;
  assign per_clk_en = cpu_en_q;
  assign peripheral_clock_out_pin = peripheral_clock_out_pin_q;
  assign fast_rc_freq_20m = freq_q;

  // bus acknowledge and read data
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        // unmapped addresses read as zero
        if (hit_a) begin
          rdata_q <= {24'h000000, ctrl_a_q};
        end else if (hit_b) begin
          rdata_q <= {24'h000000, ctrl_b_q};
        end else if (hit_st) begin
          rdata_q <= {24'h000000, ext_ready, slow_ready, fast_ready, 4'h0, changing};
        end else if (hit_fast) begin
          rdata_q <= {30'h0, fast_stby_q, 1'b0};
        end else if (hit_slow) begin
          rdata_q <= {30'h0, slow_stby_q, 1'b0};
        end else begin
          rdata_q <= 32'h00000000;
        end
      end
    end
  end

  // protection window: counts accesses after the key
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prot_cnt_q <= 3'h0;
    end else if (wr_take & hit_key & (avs_writedata[7:0] == PROTECT_KEY)) begin
      prot_cnt_q <= `PROTECT_WINDOW;
    end else if ((wr_take | rd_take) & unlocked) begin
      prot_cnt_q <= prot_cnt_q - 3'h1;
    end
  end

  // protected control registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= `CTRL_A_RESET;
      ctrl_b_q <= `CTRL_B_RESET;
      fast_stby_q <= 1'b0;
      slow_stby_q <= 1'b0;
      ext_lock_q <= 1'b0;
    end else if (wr_take & unlocked) begin
      if (hit_a) begin
        // select frozen once an external switch is pending
        if (!ext_lock_q) begin
          ctrl_a_q[`SEL_MSB:`SEL_LSB] <= avs_writedata[`SEL_MSB:`SEL_LSB];
          ext_lock_q <= (avs_writedata[`SEL_MSB:`SEL_LSB] == `SRC_EXT);
        end
        ctrl_a_q[`PERIPHERAL_CLOCK_OUT_PIN_BIT] <= avs_writedata[`PERIPHERAL_CLOCK_OUT_PIN_BIT];
      end else if (hit_b) begin
        ctrl_b_q[`PDIV_MSB:`PEN_BIT] <= avs_writedata[`PDIV_MSB:`PEN_BIT];
      end else if (hit_fast) begin
        fast_stby_q <= avs_writedata[`RUN_IN_STANDBY_BIT_BIT];
      end else if (hit_slow) begin
        slow_stby_q <= avs_writedata[`RUN_IN_STANDBY_BIT_BIT];
      end
    end else if (ext_lock_q & (cur_src_q == `SRC_EXT)) begin
      // lock released once the external switch has happened
      ext_lock_q <= 1'b0;
    end
  end

  // strap capture after reset release
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_q <= 1'b0;
      freq_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      freq_q <= frequency_select_field;
    end
  end

  // start-up counters; cleared whenever the source is off
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fast_cnt_q <= 3'h0;
      slow_cnt_q <= 3'h0;
    end else begin
      if (!fast_rc_enable | !fast_rc_analog_ready) begin
        fast_cnt_q <= 3'h0;
      end else if (fast_rc_tick & !fast_ready) begin
        fast_cnt_q <= fast_cnt_q + 3'h1;
      end
      if (!slow_osc_enable) begin
        slow_cnt_q <= 3'h0;
      end else if (slow_osc_tick & !slow_ready) begin
        slow_cnt_q <= slow_cnt_q + 3'h1;
      end
    end
  end

  // external pin: three stages, then edge counting
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      ext_lvl_q <= 1'b0;
      ext_cnt_q <= 3'h0;
    end else begin
      ext_s1_q <= external_clock_input;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      ext_lvl_q <= ext_agree ? ext_s3_q : ext_lvl_q; // hold while stages disagree
      // no fallback: once stable it stays counted as stable
      if (!ext_pin_clock_mode) begin
        ext_cnt_q <= 3'h0;
      end else if (ext_edge & !ext_ready) begin
        ext_cnt_q <= ext_cnt_q + 3'h1;
      end
    end
  end

  // source switch and prescaler, both only at a boundary or while the main clock is stopped
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_src_q <= `SRC_FAST;
      div_q <= `DIV_RESET;
      pre_cnt_q <= 6'h00;
      cpu_en_q <= 1'b0;
      peripheral_clock_out_pin_q <= 1'b0;
    end else begin
      cpu_en_q <= wrap;
      if (take_switch) begin
        cur_src_q <= tgt_src;
        pre_cnt_q <= 6'h00;
        div_q <= div_sel;
      end else if (wrap) begin
        pre_cnt_q <= 6'h00;
        div_q <= div_sel;
      end else if (main_tick) begin
        pre_cnt_q <= pre_cnt_q + 6'h01;
      end
      // pin output toggles on each prescaled period
      if (!ctrl_a_q[`PERIPHERAL_CLOCK_OUT_PIN_BIT]) begin
        peripheral_clock_out_pin_q <= 1'b0;
      end else if (wrap) begin
        peripheral_clock_out_pin_q <= ~peripheral_clock_out_pin_q;
      end
    end
  end

endmodule // main_clock_select_prescaler

// ---- verif/clock_ctrl_monitor.sv ----
`timescale 1ns/100ps
`include "main_clock_consts.vh"
module clock_ctrl_monitor (
  input wire sys_clk,
  input wire reset_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire slow_osc_tick,
  input wire [1:0] sleep_mode,
  input wire nvm_busy,
  input wire rtc_enable,
  input wire rtc_source_ext,
  input wire watchdog_enable,
  input wire brownout_sampled,
  input wire fast_rc_enable,
  input wire slow_osc_enable,
  input wire ext_pin_clock_mode,
  input wire cpu_clk_en,
  input wire per_clk_en,
  input wire rtc_clk_en,
  input wire watchdog_clock,
  input wire brownout_clock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // opening cycle of a bus request
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // long enough idle power-down to drain the divider pipeline
  sequence s_pd_idle;
    (sleep_mode == `MODE_POWERDOWN && !nvm_busy) [*6];
  endsequence
  a_bus_ack: assert property (s_req_open |=> !avs_waitrequest)
    else $error("bus request not acknowledged");
  a_cpu_per_pair: assert property (cpu_clk_en == per_clk_en)
    else $error("core and peripheral enables differ");
  a_pd_stop: assert property (s_pd_idle |-> !cpu_clk_en)
    else $error("main clock runs in idle power-down");
  a_main_source_on: assert property (sleep_mode == `MODE_ACTIVE |-> fast_rc_enable || slow_osc_enable
    || ext_pin_clock_mode)
    else $error("no source on in active mode");
  a_wdt_request: assert property (watchdog_enable |-> slow_osc_enable)
    else $error("watchdog request not served");
  a_wdt_clock: assert property (watchdog_clock == (watchdog_enable && slow_osc_tick))
    else $error("watchdog clock wrong");
  a_bod_clock: assert property (brownout_clock == (brownout_sampled && slow_osc_tick))
    else $error("brownout clock wrong");
  a_rtc_route: assert property (rtc_clk_en && !rtc_source_ext |-> rtc_enable && slow_osc_tick)
    else $error("counter clock misrouted");
endmodule // clock_ctrl_monitor

bind main_clock_select_prescaler clock_ctrl_monitor u_mon (.*);

// ---- verif/main_clock_select_prescaler_test.sv ----
`timescale 1ns/100ps
`include "main_clock_consts.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module main_clock_select_prescaler_test;
  logic sys_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, frequency_select_field = 1;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, rd;
  logic [1:0] sleep_mode = 0;
  logic nvm_busy = 0, periph_main_request = 0, rtc_enable = 0, rtc_source_ext = 0;
  logic watchdog_enable = 0, brownout_sampled = 0, ext_run = 0;
  wire avs_waitrequest, fast_rc_tick, fast_rc_analog_ready, slow_osc_tick, external_clock_input;
  wire fast_rc_enable, slow_osc_enable, ext_pin_clock_mode, fast_rc_freq_20m, cpu_clk_en, per_clk_en;
  wire rtc_clk_en, watchdog_clock, brownout_clock, peripheral_clock_out_pin;
  wire [31:0] avs_readdata;
  int miscompares = 0, cmp_count = 0, p, cnt[4], d[4];
  int codes[11] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12};
  int divs[11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
  main_clock_select_prescaler uut (.*);
  osc_model osc (.*);
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // pulse tallies, non-blocking so tasks read them race-free
  always @(posedge sys_clk) begin
    cnt[0] <= cnt[0] + watchdog_clock;
    cnt[1] <= cnt[1] + brownout_clock;
    cnt[2] <= cnt[2] + rtc_clk_en;
    cnt[3] <= cnt[3] + cpu_clk_en;
  end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one avalon access; request held until waitrequest seen low
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= dat;
    avs_write <= is_wr;
    avs_read <= !is_wr;
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    if (n >= 20) begin miscompares++; stop_test(); end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus(1, a, dat);
  endtask
  task automatic unlock;
    bus(1, 8'h80, 32'ha5);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  // poll status until the changing flag drops
  task automatic wait_idle;
    int n;
    n = 0;
    do begin bus(0, 8'h0c, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 60);
    if (n >= 60) begin miscompares++; stop_test(); end
  endtask
  // spacing of core enable pulses, last of three periods
  task automatic period(output int q);
    int n;
    n = 0;
    repeat (3) begin
      q = 0;
      do begin @(posedge sys_clk); q++; n++; end while (cpu_clk_en !== 1'b1 && n < 300);
    end
    if (n >= 300) begin miscompares++; stop_test(); end
  endtask
  task automatic window(input int c);
    int s[4];
    s = cnt;
    repeat (c) @(posedge sys_clk);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask
  task automatic t_reset;
    rd_chk("control_a", 8'h00, 32'h00);
    rd_chk("control_b", 8'h04, 32'h11);
    rd_chk("unmapped", 8'h44, 32'h00);
    rd_chk("status_reset", 8'h0c, 32'h20);
    `CHK("freq_20m", frequency_select_field, fast_rc_freq_20m)
    period(p);
    `CHK("reset_div", 6, p)
    $display("reset test done");
  endtask
  task automatic t_prot;
    logic v;
    wr(8'h04, 32'h01);
    rd_chk("no_key", 8'h04, 32'h11);
    unlock();
    repeat (4) bus(0, 8'h0c, 32'h0);
    wr(8'h04, 32'h01);
    rd_chk("late_write", 8'h04, 32'h11);
    foreach (codes[i]) begin
      unlock();
      wr(8'h04, codes[i] * 2 + 1);
      period(p);
      `CHK("divider", divs[i], p)
    end
    unlock();
    wr(8'h04, 32'h00);
    period(p);
    `CHK("undivided", 1, p)
    unlock();
    wr(8'h04, 32'h11);
    unlock();
    wr(8'h00, 32'h80);
    rd_chk("peripheral_clock_out_pin_bit", 8'h00, 32'h80);
    v = peripheral_clock_out_pin;
    repeat (6) @(posedge sys_clk);
    `CHK("peripheral_clock_out_pin_toggle", ~v, peripheral_clock_out_pin)
    unlock();
    wr(8'h00, 32'h00);
    @(posedge sys_clk);
    `CHK("peripheral_clock_out_pin_off", 1'b0, peripheral_clock_out_pin)
    $display("prescaler test done");
  endtask
  task automatic t_slow;
    unlock();
    wr(8'h00, 32'h01);
    bus(0, 8'h0c, 32'h0);
    `CHK("changing", 1'b1, rd[0])
    wait_idle();
    `CHK("fast_off", 1'b0, fast_rc_enable)
    period(p);
    `CHK("slow_div", 48, p)
    unlock();
    wr(8'h00, 32'h00);
    wait_idle();
    unlock();
    wr(8'h00, 32'h03);
    window(40);
    rd_chk("no_source", 8'h0c, 32'h21);
    unlock();
    wr(8'h00, 32'h00);
    wait_idle();
    $display("switch test done");
  endtask
  task automatic t_async;
    watchdog_enable <= 1;
    rtc_enable <= 1;
    @(posedge sys_clk);
    `CHK("slow_on", 1'b1, slow_osc_enable)
    window(60);
    `CHK("wdt_runs", 1'b1, d[0] > 0)
    `CHK("bod_idle", 0, d[1])
    `CHK("rtc_runs", 1'b1, d[2] > 0)
    rd_chk("slow_ready", 8'h0c, 32'h60);
    brownout_sampled <= 1;
    rtc_source_ext <= 1;
    window(60);
    `CHK("bod_runs", 1'b1, d[1] > 0)
    `CHK("pin_mode", 1'b1, ext_pin_clock_mode)
    {watchdog_enable, rtc_enable, brownout_sampled, rtc_source_ext} <= 4'h0;
    window(4);
    `CHK("slow_off", 1'b0, slow_osc_enable)
    $display("request test done");
  endtask
  task automatic t_sleep;
    sleep_mode <= `MODE_POWERDOWN;
    nvm_busy <= 1;
    window(30);
    `CHK("pd_busy", 1'b1, d[3] > 0)
    nvm_busy <= 0;
    window(10);
    window(30);
    `CHK("pd_stop", 0, d[3])
    sleep_mode <= `MODE_IDLE;
    window(30);
    `CHK("idle_runs", 1'b1, d[3] > 0)
    sleep_mode <= `MODE_STANDBY;
    window(10);
    window(30);
    `CHK("sb_stop", 0, d[3])
    periph_main_request <= 1;
    window(30);
    `CHK("sb_request", 1'b1, d[3] > 0)
    periph_main_request <= 0;
    unlock();
    wr(8'h40, 32'h02);
    window(30);
    `CHK("sb_keep_on", 1'b1, d[3] > 0)
    sleep_mode <= `MODE_ACTIVE;
    unlock();
    wr(8'h40, 32'h00);
    $display("sleep test done");
  endtask
  task automatic t_ext;
    unlock();
    wr(8'h00, 32'h02);
    window(60);
    bus(0, 8'h0c, 32'h0);
    `CHK("ext_wait", 1'b1, rd[0])
    `CHK("ext_pin", 1'b1, ext_pin_clock_mode)
    unlock();
    wr(8'h00, 32'h00);
    rd_chk("locked", 8'h00, 32'h02);
    ext_run <= 1;
    wait_idle();
    `CHK("ext_stable", 1'b1, rd[7])
    frequency_select_field <= 0;
    reset_n <= 0;
    window(3);
    reset_n <= 1;
    @(posedge sys_clk);
    rd_chk("after_reset", 8'h00, 32'h00);
    `CHK("freq_16m", 1'b0, fast_rc_freq_20m)
    $display("external test done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    window(10);
    t_reset();
    t_prot();
    t_slow();
    t_async();
    t_sleep();
    t_ext();
    stop_test();
  end
endmodule // main_clock_select_prescaler_test

// ---- verif/osc_model.sv ----
`timescale 1ns/100ps
module osc_model (
  input wire sys_clk,
  input wire reset_n,
  input wire fast_rc_enable,
  input wire slow_osc_enable,
  input wire ext_pin_clock_mode,
  input wire ext_run,
  output reg fast_rc_tick,
  output reg fast_rc_analog_ready,
  output reg slow_osc_tick,
  output reg external_clock_input
);
  reg [1:0] warm_q; // analog warm-up count
  reg [2:0] slow_q; // slow source runs at one eighth rate
  reg [1:0] ext_q; // external pin half period
  // a source only swings while enabled; no free ticks to hide gating faults
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {warm_q, slow_q, ext_q} <= 7'h00;
      {fast_rc_tick, fast_rc_analog_ready, slow_osc_tick, external_clock_input} <= 4'h0;
    end else begin
      warm_q <= !fast_rc_enable ? 2'h0 : (warm_q == 2'h3 ? warm_q : warm_q + 2'h1);
      fast_rc_analog_ready <= fast_rc_enable && warm_q == 2'h3;
      fast_rc_tick <= fast_rc_enable && fast_rc_analog_ready;
      slow_q <= slow_osc_enable ? slow_q + 3'h1 : 3'h0;
      slow_osc_tick <= slow_osc_enable && slow_q == 3'h7;
      ext_q <= ext_q + 2'h1;
      // ext_run low models a dead external clock
      if (ext_pin_clock_mode && ext_run && ext_q == 2'h3) begin
        external_clock_input <= !external_clock_input;
      end
    end
  end
endmodule // osc_model
